/* hw/frc_regs.sv */
// Read-only bank of frame rate capability registers with a simple request port.
`default_nettype none

module frc_regs
    import frc_pkg::*;
#(
    parameter logic [RATE_COUNT-1:0] CAPS_QQVGA_YUV444 = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_QVGA_YUV422  = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_YUV411   = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_YUV422   = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_RGB      = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_MONO8    = CAPS_DEFAULT
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        req_rd,
    input  wire logic                        req_wr,
    input  wire logic [frc_pkg::ADDR_W-1:0]  req_offset,
    input  wire logic [frc_pkg::DATA_W-1:0]  req_wdata,
    output var  logic                        rsp_valid,
    output var  logic                        rsp_err,
    output var  logic [frc_pkg::DATA_W-1:0]  rsp_data
);
    import frc_pkg::*;

    frc_rom_if rom_link ();

    logic                  req_any;
    logic                  req_hit;
    logic [DATA_W-1:0]     next_rsp_data;
    logic                  next_rsp_err;
    logic [DATA_W-1:0]     wdata_unused;

    // Request decode: the offset picks a table entry when it lands in the bank.
    assign req_any        = req_rd | req_wr;
    assign req_hit        = offset_mapped(req_offset);
    assign rom_link.index = offset_index(req_offset);
    assign wdata_unused   = req_wdata;

    // Answer selection: reads return the table word, writes are acknowledged and dropped.
    assign next_rsp_data = (req_rd && req_hit) ? rom_link.word : RSP_DATA_RST;
    assign next_rsp_err  = req_any && !req_hit;

    frc_cap_table #(
        .CAPS_QQVGA_YUV444 (CAPS_QQVGA_YUV444),
        .CAPS_QVGA_YUV422  (CAPS_QVGA_YUV422),
        .CAPS_VGA_YUV411   (CAPS_VGA_YUV411),
        .CAPS_VGA_YUV422   (CAPS_VGA_YUV422),
        .CAPS_VGA_RGB      (CAPS_VGA_RGB),
        .CAPS_VGA_MONO8    (CAPS_VGA_MONO8)
    ) u_table (
        .rom (rom_link.table_side)
    );

    // Answer registers: one cycle after any request, cleared under reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_err   <= 1'b0;
            rsp_data  <= RSP_DATA_RST;
        end else begin
            rsp_valid <= req_any;
            rsp_err   <= next_rsp_err;
            rsp_data  <= next_rsp_data;
        end
    end

    // Expected words, built independently of the table for the checks below.
    logic [DATA_W-1:0] exp_qqvga;
    logic [DATA_W-1:0] exp_qvga;
    logic [DATA_W-1:0] exp_mono8;
    assign exp_qqvga = rate_word(CAPS_QQVGA_YUV444 & ALLOW_QQVGA);
    assign exp_qvga  = rate_word(CAPS_QVGA_YUV422);
    assign exp_mono8 = rate_word(CAPS_VGA_MONO8);

    // Every request is answered on the next edge and only then.
    property p_answer_latency;
        @(posedge sys_clk) disable iff (rst)
        req_any |=> rsp_valid;
    endproperty
    a_answer_latency: assert property (p_answer_latency) else $error("Request not answered next cycle.");

    // No answer appears in a cycle that follows an idle edge.
    property p_no_spurious_answer;
        @(posedge sys_clk) disable iff (rst)
        !req_any |=> !rsp_valid;
    endproperty
    a_no_spurious_answer: assert property (p_no_spurious_answer) else $error("Answer without request.");

    // Reserved bits 8 to 31 of the register, low word bits, always read zero.
    property p_reserved_zero;
        @(posedge sys_clk) disable iff (rst)
        rsp_valid |-> (rsp_data[WORD_MSB-RATE_COUNT:0] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero.");

    // The 160x120 register never reports 1.875 or 3.75 fps.
    property p_qqvga_low_rates;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_QQVGA_YUV444) |=> (rsp_data == exp_qqvga) && (rsp_data[31:30] == 2'b00);
    endproperty
    a_qqvga_low_rates: assert property (p_qqvga_low_rates) else $error("160x120 word wrong.");

    // Rate 0 lands on the word MSB and rate 7 on word bit 24.
    property p_msb_first;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_QVGA_YUV422) |=>
            (rsp_data[31] == CAPS_QVGA_YUV422[0]) && (rsp_data[24] == CAPS_QVGA_YUV422[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Bit order not MSB first.");

    // A read of the last register returns its full mask.
    property p_last_register;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_VGA_MONO8) |=> (rsp_data == exp_mono8) && !rsp_err;
    endproperty
    a_last_register: assert property (p_last_register) else $error("Last register read wrong.");

    // Offsets outside the bank, or unaligned, answer with an error and zero data.
    property p_unmapped;
        @(posedge sys_clk) disable iff (rst)
        (req_any && !offset_mapped(req_offset)) |=> rsp_err && (rsp_data == '0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");

    // A write leaves the word that a later read returns unchanged.
    property p_write_no_effect;
        @(posedge sys_clk) disable iff (rst)
        (req_wr && req_offset == OFF_QVGA_YUV422) ##1 (req_rd && req_offset == OFF_QVGA_YUV422)
            |=> (rsp_data == exp_qvga);
    endproperty
    a_write_no_effect: assert property (p_write_no_effect) else $error("Write altered a register.");

    // A plain write answers with zero data and no error when mapped.
    property p_write_answer;
        @(posedge sys_clk) disable iff (rst)
        (req_wr && !req_rd && offset_mapped(req_offset)) |=> rsp_valid && !rsp_err && (rsp_data == '0);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("Write answer malformed.");

    // Expected words of the middle registers, built straight from their masks.
    logic [DATA_W-1:0] exp_vga411;
    logic [DATA_W-1:0] exp_vga422;
    logic [DATA_W-1:0] exp_rgb;
    assign exp_vga411 = rate_word(CAPS_VGA_YUV411);
    assign exp_vga422 = rate_word(CAPS_VGA_YUV422);
    assign exp_rgb    = rate_word(CAPS_VGA_RGB);

    // A read of the 320x240 register returns its whole word.
    property p_read_qvga;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_QVGA_YUV422) |=> rsp_valid && !rsp_err && (rsp_data == exp_qvga);
    endproperty
    a_read_qvga: assert property (p_read_qvga) else $error("320x240 word wrong.");

    // A read of the 640x480 4:1:1 register returns its whole word.
    property p_read_vga411;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_VGA_YUV411) |=> rsp_valid && !rsp_err && (rsp_data == exp_vga411);
    endproperty
    a_read_vga411: assert property (p_read_vga411) else $error("640x480 4:1:1 word wrong.");

    // A read of the 640x480 4:2:2 register returns its whole word.
    property p_read_vga422;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_VGA_YUV422) |=> rsp_valid && !rsp_err && (rsp_data == exp_vga422);
    endproperty
    a_read_vga422: assert property (p_read_vga422) else $error("640x480 4:2:2 word wrong.");

    // A read of the 640x480 RGB register returns its whole word.
    property p_read_rgb;
        @(posedge sys_clk) disable iff (rst)
        (req_rd && req_offset == OFF_VGA_RGB) |=> rsp_valid && !rsp_err && (rsp_data == exp_rgb);
    endproperty
    a_read_rgb: assert property (p_read_rgb) else $error("640x480 RGB word wrong.");

    // Any access that lands on a register is answered without an error.
    property p_mapped_no_err;
        @(posedge sys_clk) disable iff (rst)
        (req_any && offset_mapped(req_offset)) |=> !rsp_err;
    endproperty
    a_mapped_no_err: assert property (p_mapped_no_err) else $error("Mapped access flagged.");

    // The error flag only stands together with an answer.
    property p_err_with_valid;
        @(posedge sys_clk) disable iff (rst)
        rsp_err |-> rsp_valid;
    endproperty
    a_err_with_valid: assert property (p_err_with_valid) else $error("Error flag without answer.");

    // A refused access never leaks register contents.
    property p_err_data_zero;
        @(posedge sys_clk) disable iff (rst)
        rsp_err |-> (rsp_data == '0);
    endproperty
    a_err_data_zero: assert property (p_err_data_zero) else $error("Refused access returned data.");

    // Data lines stay at zero while no answer stands.
    property p_quiet_data;
        @(posedge sys_clk) disable iff (rst)
        !rsp_valid |-> (rsp_data == '0);
    endproperty
    a_quiet_data: assert property (p_quiet_data) else $error("Data without answer.");

    // Every plain write, mapped or not, answers with zero data.
    property p_write_zero;
        @(posedge sys_clk) disable iff (rst)
        (req_wr && !req_rd) |=> (rsp_data == '0);
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("Write returned data.");

    // The edge after a reset edge shows a quiet answer port.
    property p_reset_clear;
        @(posedge sys_clk)
        rst |=> !rsp_valid && !rsp_err && (rsp_data == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Answer port not cleared by reset.");

    // Main scenarios.
    c_read_first: cover property (@(posedge sys_clk) disable iff (rst) req_rd && req_offset == OFF_QQVGA_YUV444);
    c_read_and_write: cover property (@(posedge sys_clk) disable iff (rst) req_rd && req_wr);
    c_read_last: cover property (@(posedge sys_clk) disable iff (rst) req_rd && req_offset == OFF_VGA_MONO8);
    c_write_then_read: cover property (@(posedge sys_clk) disable iff (rst) req_wr ##1 req_rd);
    c_unmapped: cover property (@(posedge sys_clk) disable iff (rst) req_any && !offset_mapped(req_offset));
endmodule : frc_regs
`default_nettype wire

/* hw/frc_pkg.sv */
// Constants and helpers shared by the frame rate capability register bank.
`default_nettype none
package frc_pkg;
    // Bus widths and bank geometry.
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned RATE_COUNT = 8;
    localparam int unsigned REG_COUNT  = 6;
    localparam int unsigned IDX_W      = 3;

    // Byte offsets of the capability registers from the inquiry base.
    localparam logic [ADDR_W-1:0] OFF_QQVGA_YUV444 = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_QVGA_YUV422  = 12'h204;
    localparam logic [ADDR_W-1:0] OFF_VGA_YUV411   = 12'h208;
    localparam logic [ADDR_W-1:0] OFF_VGA_YUV422   = 12'h20c;
    localparam logic [ADDR_W-1:0] OFF_VGA_RGB      = 12'h210;
    localparam logic [ADDR_W-1:0] OFF_VGA_MONO8    = 12'h214;
    localparam logic [ADDR_W-1:0] OFF_STRIDE       = 12'h004;

    // Rate n sits at word bit (WORD_MSB - n); bit 0 of the register is the word MSB.
    localparam int unsigned WORD_MSB = 31;

    // Rates that each mode may report at all; the 160x120 mode never reports 1.875 or 3.75 fps.
    localparam logic [RATE_COUNT-1:0] ALLOW_QQVGA = 8'hfc;
    localparam logic [RATE_COUNT-1:0] ALLOW_ALL   = 8'hff;

    // Default support masks, rate n in mask bit n (1.875, 3.75, 7.5, 15, 30, 60, 120, 240 fps).
    localparam logic [RATE_COUNT-1:0] CAPS_DEFAULT = 8'hff;

    // Reset value of the answer registers.
    localparam logic [DATA_W-1:0] RSP_DATA_RST = 32'h0000_0000;

    // Places an 8-bit rate mask into the MSB-first word layout with reserved bits at zero.
    function automatic logic [DATA_W-1:0] rate_word(input logic [RATE_COUNT-1:0] mask);
        logic [DATA_W-1:0] w;
        w = '0;
        for (int n = 0; n < RATE_COUNT; n++) begin
            w[WORD_MSB-n] = mask[n];
        end
        return w;
    endfunction : rate_word

    // True when the offset lands on one of the six capability registers.
    function automatic logic offset_mapped(input logic [ADDR_W-1:0] off);
        return (off >= OFF_QQVGA_YUV444) && (off <= OFF_VGA_MONO8) && (off[1:0] == 2'b00);
    endfunction : offset_mapped

    // Register index of a mapped offset, counted from the first capability register.
    function automatic logic [IDX_W-1:0] offset_index(input logic [ADDR_W-1:0] off);
        logic [ADDR_W-1:0] d;
        d = off - OFF_QQVGA_YUV444;
        return d[IDX_W+1:2];
    endfunction : offset_index
endpackage : frc_pkg
`default_nettype wire

/* hw/frc_rom_if.sv */
// Link between the request logic and the capability table.
`default_nettype none
interface frc_rom_if;
    import frc_pkg::*;
    logic [IDX_W-1:0]  index;
    logic [DATA_W-1:0] word;

    modport table_side (input index, output word);
    modport user_side  (output index, input word);
endinterface : frc_rom_if
`default_nettype wire

/* hw/frc_cap_table.sv */
// Constant table of frame rate capability words, one per low-resolution mode.
`default_nettype none
module frc_cap_table
    import frc_pkg::*;
#(
    parameter logic [RATE_COUNT-1:0] CAPS_QQVGA_YUV444 = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_QVGA_YUV422  = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_YUV411   = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_YUV422   = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_RGB      = CAPS_DEFAULT,
    parameter logic [RATE_COUNT-1:0] CAPS_VGA_MONO8    = CAPS_DEFAULT
) (
    frc_rom_if.table_side rom
);
    // Words are fixed at elaboration; nothing can overwrite them.
    logic [DATA_W-1:0] caps [REG_COUNT];

    assign caps[0] = rate_word(CAPS_QQVGA_YUV444 & ALLOW_QQVGA);
    assign caps[1] = rate_word(CAPS_QVGA_YUV422 & ALLOW_ALL);
    assign caps[2] = rate_word(CAPS_VGA_YUV411 & ALLOW_ALL);
    assign caps[3] = rate_word(CAPS_VGA_YUV422 & ALLOW_ALL);
    assign caps[4] = rate_word(CAPS_VGA_RGB & ALLOW_ALL);
    assign caps[5] = rate_word(CAPS_VGA_MONO8 & ALLOW_ALL);

    // Out-of-range indices select an all-zero word.
    assign rom.word = (rom.index < IDX_W'(REG_COUNT)) ? caps[rom.index] : RSP_DATA_RST;
endmodule : frc_cap_table
`default_nettype wire

/* verif/frc_host_model.sv */
// Host model that issues requests to the capability bank.
`default_nettype none
module frc_host_model
    import frc_pkg::*;
#(
    parameter logic [47:0] INQ_BASE = 48'hffff_f0f0_0000
) (
    input  wire logic                       sys_clk,
    output var  logic                       req_rd,
    output var  logic                       req_wr,
    output var  logic [frc_pkg::ADDR_W-1:0] req_offset,
    output var  logic [frc_pkg::DATA_W-1:0] req_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Inputs of the bank are quiet at time zero.
    initial begin
        req_rd     = 1'b0;
        req_wr     = 1'b0;
        req_offset = 12'h000;
        req_wdata  = 32'h0000_0000;
    end
    // Presents one request at the falling edge.
    task automatic issue(input logic rd, input logic wr, input logic [47:0] addr, input logic [31:0] wd);
        @(negedge sys_clk);
        req_rd     = rd;
        req_wr     = wr;
        req_offset = ADDR_W'(addr - INQ_BASE);
        req_wdata  = wd;
    endtask : issue
    // Drops the request; released lines show the inverse of their last value.
    task automatic release_bus();
        @(negedge sys_clk);
        req_rd     = 1'b0;
        req_wr     = 1'b0;
        req_offset = ~req_offset;
        req_wdata  = ~req_wdata;
    endtask : release_bus
endmodule : frc_host_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking testbench for the capability bank.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import frc_pkg::*;
    localparam logic [47:0] BASE     = 48'hffff_f0f0_0000;
    localparam logic [7:0]  CAPS [6] = '{8'hff, 8'h5a, 8'h81, 8'h3c, 8'hc3, 8'h0f};
    logic                sys_clk = 1'b0;
    logic                rst     = 1'b1;
    logic                req_rd;
    logic                req_wr;
    logic [ADDR_W-1:0]   req_offset;
    logic [DATA_W-1:0]   req_wdata;
    logic                rsp_valid;
    logic                rsp_err;
    logic [DATA_W-1:0]   rsp_data;
    int                  miscompares = 0;
    int                  num_checks  = 0;
    // The clock toggles every half period of 25 ns.
    always #25 sys_clk = ~sys_clk;
    frc_regs #(.CAPS_QQVGA_YUV444(CAPS[0]), .CAPS_QVGA_YUV422(CAPS[1]), .CAPS_VGA_YUV411(CAPS[2]),
        .CAPS_VGA_YUV422(CAPS[3]), .CAPS_VGA_RGB(CAPS[4]), .CAPS_VGA_MONO8(CAPS[5])) u_frc_regs (
        .sys_clk(sys_clk), .rst(rst), .req_rd(req_rd), .req_wr(req_wr), .req_offset(req_offset),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data));
    frc_host_model #(.INQ_BASE(BASE)) u_frc_host_model (.sys_clk(sys_clk), .req_rd(req_rd),
        .req_wr(req_wr), .req_offset(req_offset), .req_wdata(req_wdata));
    // Rate n lands on data bit 31-n; the 160x120 mode never shows its two slowest rates.
    function automatic logic [31:0] exp_word(input int i);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int n = 0; n < 8; n++) begin
            w[31-n] = (i == 0 && n < 2) ? 1'b0 : CAPS[i][n];
        end
        return w;
    endfunction : exp_word
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One request, judged in the cycle after the edge that takes it.
    task automatic op(input logic rd, input logic wr, input logic [11:0] off, input logic err, input logic [31:0] d);
        u_frc_host_model.issue(rd, wr, BASE + 48'(off), ~d);
        @(posedge sys_clk);
        #1;
        chk("rsp_valid", 32'h1, 32'(rsp_valid));
        chk("rsp_err", 32'(err), 32'(rsp_err));
        chk("rsp_data", d, rsp_data);
    endtask : op
    // The answer stands for one cycle only once requests stop.
    task automatic idle();
        u_frc_host_model.release_bus();
        @(posedge sys_clk);
        #1;
        chk("rsp_valid idle", 32'h0, 32'(rsp_valid));
    endtask : idle
    task automatic t_reset();
        chk("rsp_valid rst", 32'h0, 32'(rsp_valid));
        chk("rsp_err rst", 32'h0, 32'(rsp_err));
        chk("rsp_data rst", 32'h0, rsp_data);
    endtask : t_reset
    // Reset in mid-run drops the request that it meets, and reads work right after it.
    task automatic t_mid_reset();
        u_frc_host_model.issue(1'b1, 1'b0, BASE + 48'h204, 32'h0);
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        chk("rsp_valid mid rst", 32'h0, 32'(rsp_valid));
        chk("rsp_err mid rst", 32'h0, 32'(rsp_err));
        chk("rsp_data mid rst", 32'h0, rsp_data);
        u_frc_host_model.release_bus();
        rst = 1'b0;
        op(1'b1, 1'b0, 12'h204, 1'b0, exp_word(1));
        idle();
    endtask : t_mid_reset
    // All six registers back to back.
    task automatic t_read_all();
        for (int i = 0; i < 6; i++) begin
            op(1'b1, 1'b0, 12'(12'h200 + 4 * i), 1'b0, exp_word(i));
        end
        idle();
    endtask : t_read_all
    // Writes to all six registers answer zero; 0x204 and 0x200 read back unchanged; read and write together acts as read.
    task automatic t_write();
        for (int i = 0; i < 6; i++) begin
            op(1'b0, 1'b1, 12'(12'h200 + 4 * i), 1'b0, 32'h0);
        end
        op(1'b0, 1'b1, 12'h204, 1'b0, 32'h0);
        op(1'b1, 1'b0, 12'h204, 1'b0, exp_word(1));
        op(1'b1, 1'b0, 12'h200, 1'b0, exp_word(0));
        op(1'b1, 1'b1, 12'h214, 1'b0, exp_word(5));
        idle();
    endtask : t_write
    // Offsets outside the bank or off a word boundary are refused.
    task automatic t_unmapped();
        op(1'b1, 1'b0, 12'h218, 1'b1, 32'h0);
        op(1'b1, 1'b0, 12'h1fc, 1'b1, 32'h0);
        op(1'b1, 1'b0, 12'h202, 1'b1, 32'h0);
        op(1'b0, 1'b1, 12'h218, 1'b1, 32'h0);
        idle();
    endtask : t_unmapped
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Main sequence.
    initial begin
        repeat (5) @(negedge sys_clk);
        t_reset();
        rst = 1'b0;
        t_read_all();
        t_write();
        t_unmapped();
        t_mid_reset();
        stop_test();
    end
    // Watchdog well beyond the run of about 33 cycles.
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
